/* File: src/dtpb_defs.vh */
`ifndef DTPB_DEFS_VH
`define DTPB_DEFS_VH

// Register addresses
`define DTPB_ADDR_CTL1      4'h0
`define DTPB_ADDR_CTL2      4'h1
`define DTPB_ADDR_HIGH      4'h2
`define DTPB_ADDR_TIMER     4'h3
`define DTPB_ADDR_DUTY      4'h4
`define DTPB_ADDR_PSCV      4'h5
`define DTPB_ADDR_TONE_CTL  4'h6
`define DTPB_ADDR_TONE_FREQ 4'h7
`define DTPB_ADDR_IFLAG     4'h8
`define DTPB_ADDR_IENABLE   4'h9
`define DTPB_ADDR_GLOBAL    4'hA

// First control register fields
`define DTPB_RUN_BIT        0
`define DTPB_RELOAD_SEL_BIT 1
`define DTPB_ONE_SHOT_BIT   2
`define DTPB_PWM_LOW_BIT    6
`define DTPB_PWM_OE_BIT     7

// Second control register fields
`define DTPB_PS_SEL_MSB     2
`define DTPB_PS_EN_N_BIT    3
`define DTPB_EDGE_SEL_BIT   4
`define DTPB_CLK_SEL_BIT    5

// Shared high bits register fields
`define DTPB_RELOAD_HI_MSB  5
`define DTPB_RELOAD_HI_LSB  4
`define DTPB_DUTY_HI_MSB    1

// Other fields
`define DTPB_TONE_EN_BIT    7
`define DTPB_TONE_SRC_BIT   3
`define DTPB_FLAG_BIT       3
`define DTPB_GIE_BIT        0

// Reset and fixed values
`define DTPB_CTL1_RST       8'h00
`define DTPB_CTL2_RST       8'h08
`define DTPB_CNT_FULL       10'h3FF
`define DTPB_CNT_ZERO       10'h000

`endif

/* File: src/dtpb_top.v */
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "dtpb_defs.vh"

module dtpb_top #(
  parameter CNT_W = 10,
  parameter PS_W  = 8
) (
  input  wire       clock_in,
  input  wire       rst_n_in,
  input  wire [3:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  input  wire       ext_clk_pin_in,
  input  wire       cmp_enable_in,
  input  wire       cmp_level_in,
  output reg  [7:0] rdata_out,
  output reg        pin_out,
  output reg        pin_oe_out,
  output reg        irq_out
);

  // Software registers
  reg  [7:0]       ctl1_r;
  reg  [7:0]       ctl2_r;
  reg  [1:0]       reload_hi_r;
  reg  [1:0]       duty_hi_r;
  reg  [CNT_W-1:0] reload_r;
  reg  [CNT_W-1:0] duty_buf_r;
  reg  [CNT_W-1:0] duty_act_r;
  reg              tone_en_r;
  reg  [3:0]       tone_freq_r;
  reg              flag_r;
  reg              flag_ie_r;
  reg              gie_r;

  // Timer state
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg              stopped_r;
  reg              stopped_nxt;
  reg  [PS_W-1:0]  ps_cnt_r;
  reg              ext_prev_r;
  reg  [7:0]       tone_cnt_r;
  reg              tone_r;
  reg              pin_nxt;
  reg              oe_nxt;
  reg  [7:0]       rd_nxt;

  wire             run;
  wire             wr_timer;
  wire             wr_ctl1;
  wire             ext_rise;
  wire             ext_fall;
  wire             ext_edge;
  wire             src_tick;
  wire [PS_W-1:0]  ps_mask;
  wire             ps_wrap;
  wire             ps_tick;
  wire             tmr_tick;
  wire             underflow;
  wire             pwm_active;
  wire             pwm_wave;
  wire             tone_src;
  reg  [7:0]       tone_mask;
  wire             tone_wrap;

  assign run      = ctl1_r[`DTPB_RUN_BIT];
  assign wr_timer = wr_in && (addr_in == `DTPB_ADDR_TIMER);
  assign wr_ctl1  = wr_in && (addr_in == `DTPB_ADDR_CTL1);

  // Edge detect on external clock pin
  assign ext_rise = ext_clk_pin_in && !ext_prev_r;
  assign ext_fall = !ext_clk_pin_in && ext_prev_r;
  assign ext_edge = ctl2_r[`DTPB_EDGE_SEL_BIT] ? ext_fall : ext_rise;

  // Source select
  assign src_tick = ctl2_r[`DTPB_CLK_SEL_BIT] ? ext_edge : 1'b1;

  // Prescaler ratio 2^(n+1)
  assign ps_mask = {PS_W{1'b1}} >> (PS_W - 1 - ctl2_r[`DTPB_PS_SEL_MSB:0]);
  assign ps_wrap = &(ps_cnt_r | ~ps_mask);
  assign ps_tick = src_tick && ps_wrap;
  assign tmr_tick = ctl2_r[`DTPB_PS_EN_N_BIT] ? src_tick : ps_tick;

  assign underflow = run && !stopped_r && tmr_tick &&
                     (cnt_r == `DTPB_CNT_ZERO);

  // PWM compare
  assign pwm_active = (cnt_r < duty_act_r);
  assign pwm_wave   = pwm_active ^ ctl1_r[`DTPB_PWM_LOW_BIT];

  // Tone divider
  assign tone_src  = tone_freq_r[`DTPB_TONE_SRC_BIT] ? underflow
                                                      : ps_tick;
  assign tone_wrap = &(tone_cnt_r | ~tone_mask);

  // Tone mask 2^n - 1, toggle every 2^n events
  always @*
  begin
    tone_mask = 8'h00;
    case (tone_freq_r[2:0])
      3'h0:
      begin
        tone_mask = 8'h00;
      end
      3'h1:
      begin
        tone_mask = 8'h01;
      end
      3'h2:
      begin
        tone_mask = 8'h03;
      end
      3'h3:
      begin
        tone_mask = 8'h07;
      end
      3'h4:
      begin
        tone_mask = 8'h0F;
      end
      3'h5:
      begin
        tone_mask = 8'h1F;
      end
      3'h6:
      begin
        tone_mask = 8'h3F;
      end
      3'h7:
      begin
        tone_mask = 8'h7F;
      end
      default:
      begin
        tone_mask = 8'h00;
      end
    endcase
  end

  // Counter next value
  always @*
  begin
    cnt_nxt     = cnt_r;
    stopped_nxt = stopped_r;
    if (!run)
    begin
      stopped_nxt = 1'b0;
    end
    if (run && !stopped_r && tmr_tick)
    begin
      if (cnt_r == `DTPB_CNT_ZERO)
      begin
        if (ctl1_r[`DTPB_ONE_SHOT_BIT])
        begin
          cnt_nxt     = reload_r;
          stopped_nxt = 1'b1;
        end
        else if (ctl1_r[`DTPB_RELOAD_SEL_BIT])
        begin
          cnt_nxt = reload_r;
        end
        else
        begin
          cnt_nxt = `DTPB_CNT_FULL;
        end
      end
      else
      begin
        cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    if (wr_timer)
    begin
      stopped_nxt = 1'b0;
      if (!run)
      begin
        cnt_nxt = {reload_hi_r, wdata_in};
      end
    end
  end

  // Pin mux and read mux
  always @*
  begin
    oe_nxt  = cmp_enable_in || ctl1_r[`DTPB_PWM_OE_BIT] ||
              tone_en_r;
    pin_nxt = 1'b0;
    if (cmp_enable_in)
    begin
      pin_nxt = cmp_level_in;
    end
    else if (ctl1_r[`DTPB_PWM_OE_BIT])
    begin
      pin_nxt = pwm_wave;
    end
    else if (tone_en_r)
    begin
      pin_nxt = tone_r;
    end
    rd_nxt = 8'h00;
    case (addr_in)
      `DTPB_ADDR_CTL1:
      begin
        rd_nxt = ctl1_r;
      end
      `DTPB_ADDR_CTL2:
      begin
        rd_nxt = ctl2_r;
      end
      `DTPB_ADDR_HIGH:
      begin
        rd_nxt = {2'b00, cnt_r[9:8], 2'b00, duty_hi_r};
      end
      `DTPB_ADDR_TIMER:
      begin
        rd_nxt = cnt_r[7:0];
      end
      `DTPB_ADDR_PSCV:
      begin
        rd_nxt = ps_cnt_r;
      end
      `DTPB_ADDR_TONE_CTL:
      begin
        rd_nxt = {tone_en_r, 7'h00};
      end
      `DTPB_ADDR_TONE_FREQ:
      begin
        rd_nxt = {4'h0, tone_freq_r};
      end
      `DTPB_ADDR_IFLAG:
      begin
        rd_nxt = {4'h0, flag_r, 3'b000};
      end
      `DTPB_ADDR_IENABLE:
      begin
        rd_nxt = {4'h0, flag_ie_r, 3'b000};
      end
      `DTPB_ADDR_GLOBAL:
      begin
        rd_nxt = {7'h00, gie_r};
      end
      default:
      begin
        rd_nxt = 8'h00;
      end
    endcase
    if (!rd_in)
    begin
      rd_nxt = 8'h00;
    end
  end

  // Registers and timer
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      ctl1_r      <= `DTPB_CTL1_RST;
      ctl2_r      <= `DTPB_CTL2_RST;
      reload_hi_r <= 2'b00;
      duty_hi_r   <= 2'b00;
      reload_r    <= `DTPB_CNT_FULL;
      duty_buf_r  <= `DTPB_CNT_ZERO;
      duty_act_r  <= `DTPB_CNT_ZERO;
      tone_en_r   <= 1'b0;
      tone_freq_r <= 4'h0;
      flag_r      <= 1'b0;
      flag_ie_r   <= 1'b0;
      gie_r       <= 1'b0;
      cnt_r       <= `DTPB_CNT_FULL;
      stopped_r   <= 1'b0;
      ps_cnt_r    <= {PS_W{1'b0}};
      ext_prev_r  <= 1'b0;
      tone_cnt_r  <= 8'h00;
      tone_r      <= 1'b0;
      rdata_out   <= 8'h00;
      pin_out     <= 1'b0;
      pin_oe_out  <= 1'b0;
      irq_out     <= 1'b0;
    end
    else
    begin
      ext_prev_r <= ext_clk_pin_in;
      cnt_r      <= cnt_nxt;
      stopped_r  <= stopped_nxt;
      rdata_out  <= rd_nxt;
      pin_out    <= pin_nxt;
      pin_oe_out <= oe_nxt;
      irq_out    <= flag_r && flag_ie_r && gie_r;

      // Prescaler runs on source ticks
      if (ctl2_r[`DTPB_PS_EN_N_BIT])
      begin
        ps_cnt_r <= {PS_W{1'b0}};
      end
      else if (src_tick)
      begin
        ps_cnt_r <= ps_wrap ? {PS_W{1'b0}}
                            : ps_cnt_r + {{(PS_W-1){1'b0}}, 1'b1};
      end

      // Tone toggles on divider wrap
      if (!tone_en_r)
      begin
        tone_cnt_r <= 8'h00;
        tone_r     <= 1'b0;
      end
      else if (tone_src)
      begin
        tone_cnt_r <= tone_wrap ? 8'h00 : tone_cnt_r + 8'h01;
        if (tone_wrap)
        begin
          tone_r <= !tone_r;
        end
      end

      // Duty latched at underflow
      if (underflow)
      begin
        duty_act_r <= duty_buf_r;
      end

      // Sticky flag, set wins
      if (wr_in && (addr_in == `DTPB_ADDR_IFLAG) &&
          !wdata_in[`DTPB_FLAG_BIT])
      begin
        flag_r <= underflow;
      end
      else if (underflow)
      begin
        flag_r <= 1'b1;
      end

      if (wr_ctl1)
      begin
        ctl1_r <= wdata_in;
      end
      if (wr_in && (addr_in == `DTPB_ADDR_CTL2))
      begin
        ctl2_r <= {2'b00, wdata_in[5:0]};
      end
      if (wr_in && (addr_in == `DTPB_ADDR_HIGH))
      begin
        reload_hi_r <= wdata_in[`DTPB_RELOAD_HI_MSB:`DTPB_RELOAD_HI_LSB];
        duty_hi_r   <= wdata_in[`DTPB_DUTY_HI_MSB:0];
      end
      if (wr_timer)
      begin
        reload_r <= {reload_hi_r, wdata_in};
      end
      if (wr_in && (addr_in == `DTPB_ADDR_DUTY))
      begin
        duty_buf_r <= {duty_hi_r, wdata_in};
      end
      if (wr_in && (addr_in == `DTPB_ADDR_TONE_CTL))
      begin
        tone_en_r <= wdata_in[`DTPB_TONE_EN_BIT];
      end
      if (wr_in && (addr_in == `DTPB_ADDR_TONE_FREQ))
      begin
        tone_freq_r <= wdata_in[3:0];
      end
      if (wr_in && (addr_in == `DTPB_ADDR_IENABLE))
      begin
        flag_ie_r <= wdata_in[`DTPB_FLAG_BIT];
      end
      if (wr_in && (addr_in == `DTPB_ADDR_GLOBAL))
      begin
        gie_r <= wdata_in[`DTPB_GIE_BIT];
      end
    end
  end

endmodule // dtpb_top

`default_nettype wire

/* File: testbench/dtpb_load.sv */
`timescale 1ns/10ps
`default_nettype none
module dtpb_load (
  input  wire logic clock_in,
  input  wire logic pin_in,
  input  wire logic oe_in,
  output wire logic level_out
);
  logic last_r = 1'b0;
  // Undriven pin shows the inverse of its last level
  always @(posedge clock_in)
    if (oe_in)
      last_r <= pin_in;
  assign level_out = oe_in ? pin_in : ~last_r;
endmodule // dtpb_load
`default_nettype wire

/* File: testbench/dtpb_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module dtpb_props #(
  parameter CNT_W = 10,
  parameter PS_W  = 8
) (
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic       ext_clk_pin_in,
  input wire logic       cmp_enable_in,
  input wire logic       cmp_level_in,
  input wire logic [7:0] rdata_out,
  input wire logic       pin_out,
  input wire logic       pin_oe_out,
  input wire logic       irq_out
);
  logic pwm_r, tone_r, ie_r, gie_r;
  // Mirrors of enable bits
  always @(posedge clock_in)
    if (!rst_n_in)
      {pwm_r, tone_r, ie_r, gie_r} <= 4'h0;
    else if (wr_in)
      case (addr_in)
        4'h0: pwm_r <= wdata_in[7];
        4'h6: tone_r <= wdata_in[7];
        4'h9: ie_r <= wdata_in[3];
        4'hA: gie_r <= wdata_in[0];
        default: ;
      endcase
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  hi_read_a: assert property (rd_in && addr_in == 4'h2 |=>
    (rdata_out & 8'hCC) == 8'h00) else $error("high bits read bad");
  unmap_read_a: assert property (rd_in && addr_in > 4'hA |=>
    rdata_out == 8'h00) else $error("unmapped read not zero");
  irq_gate_a: assert property (irq_out |-> $past(ie_r) && $past(gie_r))
    else $error("irq without enables");
  irq_hold_a: assert property (irq_out && !$past(wr_in) |=> irq_out)
    else $error("flag dropped alone");
  gie_off_a: assert property (wr_in && addr_in == 4'hA && !wdata_in[0]
    |=> ##1 !irq_out) else $error("irq after global off");
  pin_dir_a: assert property ($past(rst_n_in) |->
    pin_oe_out == $past(pwm_r | tone_r | cmp_enable_in))
    else $error("pin direction wrong");
  cmp_wins_a: assert property ($past(cmp_enable_in) && $past(rst_n_in)
    |-> pin_out == $past(cmp_level_in)) else $error("comparator lost pin");
  cover property ($rose(irq_out));
  cover property (cmp_enable_in && pwm_r);
  cover property (pwm_r && tone_r && pin_oe_out);
endmodule // dtpb_props
bind dtpb_top dtpb_props #(.CNT_W(CNT_W), .PS_W(PS_W)) i_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .ext_clk_pin_in(ext_clk_pin_in), .cmp_enable_in(cmp_enable_in),
  .cmp_level_in(cmp_level_in), .rdata_out(rdata_out), .pin_out(pin_out),
  .pin_oe_out(pin_oe_out), .irq_out(irq_out));
`default_nettype wire

/* File: testbench/dtpb_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dtpb_top_tb;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, ext = 0;
  logic       cmpe = 0, cmpl = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  wire  [7:0] rdata;
  wire        pin, oe, irq, lvl;
  int         num_errors = 0, n_checks = 0, seed = 32'hC532A21B;
  int         r, d, p, h, i, t0;
  dtpb_top i_dut (.clock_in(clk), .rst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wd), .wr_in(wr), .rd_in(rd), .ext_clk_pin_in(ext),
    .cmp_enable_in(cmpe), .cmp_level_in(cmpl), .rdata_out(rdata),
    .pin_out(pin), .pin_oe_out(oe), .irq_out(irq));
  dtpb_load i_load (.clock_in(clk), .pin_in(pin), .oe_in(oe),
    .level_out(lvl));
  initial
    forever #12.5 clk = ~clk;
  // External clock, six cycles a period
  always
  begin
    repeat (3) @(posedge clk);
    ext <= ~ext;
  end
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr_t(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_t(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Bounded wait for the interrupt request
  task up;
    int c;
    c = 0;
    while (irq !== 1'b1 && c < 9000)
    begin
      @(posedge clk);
      #1 c++;
    end
    if (c >= 9000)
    begin
      num_errors++;
      $display("wrong value at %0t: no interrupt", $time);
      report_and_stop;
    end
  endtask
  // Clear again when a set won over the clear
  task clr;
    int k;
    k = 0;
    do
    begin
      wr_t(4'h8, 8'h00);
      repeat (2) @(posedge clk);
      #1 k++;
    end while (irq === 1'b1 && k < 3);
  endtask
  // Cycles between two underflows
  task per;
    clr;
    up;
    t0 = $time;
    clr;
    up;
    p = ($time - t0) / 25;
  endtask
  task cnt(input logic v);
    h = 0;
    repeat (4 * (r + 1))
    begin
      @(posedge clk);
      #1 if (lvl === v) h++;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_t(4'h1, 8'h08);
    wr_t(4'h1, 8'h02);
    rd_t(4'h5, 8'h01);
    wr_t(4'h1, 8'h08);
    rd_t(4'h3, 8'hFF);
    rd_t(4'h2, 8'h30);
    rd_t(4'hF, 8'h00);
    r = 4 + ({$random(seed)} % 8);
    wr_t(4'h2, 8'h00);
    wr_t(4'h3, r[7:0]);
    rd_t(4'h3, r[7:0]);
    rd_t(4'h3, r[7:0]);
    wr_t(4'h9, 8'h08);
    wr_t(4'hA, 8'h01);
    wr_t(4'h0, 8'h03);
    per;
    chk(p[15:0], 16'(r + 1));
    for (i = 0; i < 3; i++)
    begin
      wr_t(4'h1, i[7:0]);
      per;
      chk(p[15:0], 16'((r + 1) << (i + 1)));
    end
    for (i = 0; i < 2; i++)
    begin
      wr_t(4'h1, 8'h28 | (i[7:0] << 4));
      per;
      chk(p[15:0], 16'((r + 1) * 6));
    end
    wr_t(4'h1, 8'h08);
    wr_t(4'h0, 8'h01);
    clr;
    up;
    rd_t(4'h2, 8'h30);
    wr_t(4'h0, 8'h05);
    clr;
    up;
    rd_t(4'h3, r[7:0]);
    rd_t(4'h3, r[7:0]);
    d = 1 + ({$random(seed)} % r);
    wr_t(4'h3, r[7:0]);
    wr_t(4'h4, d[7:0]);
    wr_t(4'h0, 8'h83);
    clr;
    up;
    cnt(1'b1);
    chk(h[15:0], 16'(4 * d));
    wr_t(4'h0, 8'hC3);
    cnt(1'b0);
    chk(h[15:0], 16'(4 * d));
    wr_t(4'h4, 8'h00);
    wr_t(4'h0, 8'h83);
    clr;
    up;
    wr_t(4'h6, 8'h80);
    wr_t(4'h7, 8'h08);
    cnt(1'b1);
    chk(h[15:0], 16'h0000);
    chk({15'h0000, oe}, 16'h0001);
    wr_t(4'h0, 8'h03);
    cnt(1'b1);
    chk(h[15:0], 16'(2 * (r + 1)));
    @(posedge clk);
    cmpe <= 1'b1;
    cmpl <= 1'b1;
    @(posedge clk);
    cnt(1'b1);
    chk(h[15:0], 16'(4 * (r + 1)));
    wr_t(4'hA, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    report_and_stop;
  end
endmodule // dtpb_top_tb
`default_nettype wire
